// file: verilog/ldb_cfg.svh
// Constants for the LED dimming and blinking engine
`ifndef LDB_CFG_SVH
`define LDB_CFG_SVH
// ==========================================================
// Timing
`define LDB_CLK_HZ 100000000
`define LDB_PWM_HZ 97000
`define LDB_PWM_STEPS 256
`define LDB_PWM_DIV (`LDB_CLK_HZ / (`LDB_PWM_HZ * `LDB_PWM_STEPS))
`define LDB_DIM_HZ 190
`define LDB_DIM_DIV (`LDB_CLK_HZ / (`LDB_DIM_HZ * `LDB_PWM_STEPS))
`define LDB_BLINK_FAST_HZ 24
`define LDB_BLINK_SLOW_MS 10730
`define LDB_BLINK_FAST_DIV \
  (`LDB_CLK_HZ / (`LDB_BLINK_FAST_HZ * `LDB_PWM_STEPS))
`define LDB_BLINK_SLOW_DIV \
  (`LDB_CLK_HZ / 1000 * `LDB_BLINK_SLOW_MS / `LDB_PWM_STEPS)
`define LDB_BLINK_STEP_DIV \
  ((`LDB_BLINK_SLOW_DIV - `LDB_BLINK_FAST_DIV) / 255)
// ==========================================================
// Register offsets
`define LDB_OFS_DUTY0 5'h00
`define LDB_OFS_GRP_DUTY 5'h10
`define LDB_OFS_GRP_FREQ 5'h11
`define LDB_OFS_CTRL2 5'h12
`define LDB_OFS_MODE0 5'h13
`define LDB_OFS_OWN_ADDR 5'h17
`define LDB_OFS_TX 5'h18
`define LDB_OFS_RX 5'h19
`define LDB_OFS_STATUS 5'h1A
// ==========================================================
// Fields and reset values
`define LDB_BLINK_BIT 0
`define LDB_OWN_ADDR_RST 7'h15
`endif

// file: verilog/ldb_pkg.sv
// Types for the LED dimming and blinking engine
package ldb_pkg;
  // ========================================================
  // Serial slave states
  typedef enum logic [2:0] {
    LDB_IDLE = 3'h0,
    LDB_ADDR = 3'h1,
    LDB_ACK_A = 3'h2,
    LDB_RX = 3'h3,
    LDB_ACK_RX = 3'h4,
    LDB_TX = 3'h5,
    LDB_ACK_TX = 3'h6
  } ldb_i2c_st_t;
  // ========================================================
  // Whole state of the block
  typedef struct packed {
    logic [15:0][7:0] duty;
    logic [7:0] grp_duty;
    logic [7:0] grp_freq;
    logic [7:0] ctrl2;
    logic [31:0] mode;
    logic [6:0] own_addr;
    logic [7:0] tx_byte;
    logic [7:0] rx_byte;
    logic [7:0] rx_cnt;
    logic [7:0] rdata;
    logic [7:0] pwm_pre;
    logic [7:0] pwm_cnt;
    logic [31:0] grp_pre;
    logic [7:0] grp_cnt;
    logic [15:0] led;
    logic scl_s1;
    logic scl_s2;
    logic scl_s3;
    logic sda_s1;
    logic sda_s2;
    logic sda_s3;
    ldb_i2c_st_t st;
    logic [2:0] bitc;
    logic [7:0] sh;
    logic full;
    logic rnw;
    logic acked;
    logic nack;
    logic sda_oe;
    logic sda_o;
  } ldb_state_t;
  // Mode field of one channel
  function automatic logic [1:0] ldb_mode_of(input logic [31:0] m,
                                             input int ch);
    return m[2*ch +: 2];
  endfunction : ldb_mode_of
endpackage : ldb_pkg

// file: verilog/ldb_top.sv
// LED brightness engine with group dimming, blinking and serial slave
//
// Notes on behaviour
// - Each output has its own 97 kHz 8-bit duty PWM.
// - Dimming mode: fixed 190 Hz group PWM with 8-bit duty.
// - Blinking mode: group period 24 Hz to 10.73 s, 8-bit duty.
// - Only one group signal, ANDed with channel PWM when selected.
// - One bit per clock; data stable and sampled while SCL high.
// - SDA falling while SCL high is start; new transfer begins.
// - SDA rising while SCL high is stop; transfer ends.
// - Each byte gets one acknowledge bit; byte count unlimited.
// - Addressed receiver acknowledges every received byte.
// - Acknowledger holds SDA low through the ack clock high phase.
// - After a nack the transmitting device releases SDA high.
// - Mode 00 off, 01 on, 10 channel duty, 11 duty and group.
// - Select bit 1 picks blinking, 0 picks dimming.
//
// The address map and the strobed register port were left to the implementer.
`timescale 1ns/1ps
`include "ldb_cfg.svh"
module ldb_top
  import ldb_pkg::*;
#(
  parameter int unsigned DIM_DIV = `LDB_DIM_DIV,
  parameter int unsigned BLINK_FAST_DIV = `LDB_BLINK_FAST_DIV,
  parameter int unsigned BLINK_STEP_DIV = `LDB_BLINK_STEP_DIV
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [4:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic [15:0] led_on
);

  // ========================================================
  // State registers
  ldb_state_t r_reg;
  ldb_state_t r_next;
  logic pwm_step;
  logic grp_step;
  logic grp_on;
  logic [31:0] grp_lim;
  logic scl_hi;
  logic scl_rise;
  logic scl_fall;
  logic i2c_start;
  logic i2c_stop;

  // Reset image: lines idle high, own address LDB_OWN_ADDR_RST, everything else cleared
  function automatic ldb_state_t ldb_rst_val();
    ldb_state_t v;
    v = '0;
    v.scl_s1 = 1'b1;
    v.scl_s2 = 1'b1;
    v.scl_s3 = 1'b1;
    v.sda_s1 = 1'b1;
    v.sda_s2 = 1'b1;
    v.sda_s3 = 1'b1;
    v.own_addr = `LDB_OWN_ADDR_RST;
    v.st = LDB_IDLE;
    return v;
  endfunction : ldb_rst_val

  localparam ldb_state_t LDB_RST = ldb_rst_val();

  // ========================================================
  // Line conditions seen on the synchronised pins
  assign scl_hi = r_reg.scl_s2 && r_reg.scl_s3;
  assign scl_rise = r_reg.scl_s2 && !r_reg.scl_s3;
  assign scl_fall = !r_reg.scl_s2 && r_reg.scl_s3;
  assign i2c_start = scl_hi && r_reg.sda_s3 && !r_reg.sda_s2;
  assign i2c_stop = scl_hi && !r_reg.sda_s3 && r_reg.sda_s2;

  // Group period per step: dimming fixed, blinking stepped evenly
  always_comb begin
    if (r_reg.ctrl2[`LDB_BLINK_BIT]) begin
      grp_lim = 32'(BLINK_FAST_DIV
                + r_reg.grp_freq * BLINK_STEP_DIV);
    end else begin
      grp_lim = 32'(DIM_DIV);
    end
  end

  // Prescaler wraps and group compare
  assign pwm_step = (r_reg.pwm_pre == 8'(`LDB_PWM_DIV - 1));
  assign grp_step = (r_reg.grp_pre >= grp_lim - 32'h1);
  assign grp_on = (r_reg.grp_cnt < r_reg.grp_duty);

  // ========================================================
  // Next state
  always_comb begin
    logic [1:0] mi;
    logic ind;
    mi = 2'(reg_addr - `LDB_OFS_MODE0);
    ind = 1'b0;
    r_next = r_reg;
    // Two-stage synchronisers, third stage for edge detection
    r_next.scl_s1 = scl_in;
    r_next.scl_s2 = r_reg.scl_s1;
    r_next.scl_s3 = r_reg.scl_s2;
    r_next.sda_s1 = sda_in;
    r_next.sda_s2 = r_reg.sda_s1;
    r_next.sda_s3 = r_reg.sda_s2;

    // Register writes
    if (reg_wr) begin
      if (reg_addr < `LDB_OFS_GRP_DUTY) begin
        r_next.duty[reg_addr[3:0]] = reg_wdata;
      end else if (reg_addr == `LDB_OFS_GRP_DUTY) begin
        r_next.grp_duty = reg_wdata;
      end else if (reg_addr == `LDB_OFS_GRP_FREQ) begin
        r_next.grp_freq = reg_wdata;
      end else if (reg_addr == `LDB_OFS_CTRL2) begin
        r_next.ctrl2 = reg_wdata;
      end else if (reg_addr < `LDB_OFS_OWN_ADDR) begin
        r_next.mode[8*mi +: 8] = reg_wdata;
      end else if (reg_addr == `LDB_OFS_OWN_ADDR) begin
        r_next.own_addr = reg_wdata[6:0];
      end else if (reg_addr == `LDB_OFS_TX) begin
        r_next.tx_byte = reg_wdata;
      end
    end

    // Register reads, data stands in the following cycle only
    r_next.rdata = 8'h00;
    if (reg_rd) begin
      if (reg_addr < `LDB_OFS_GRP_DUTY) begin
        r_next.rdata = r_reg.duty[reg_addr[3:0]];
      end else if (reg_addr == `LDB_OFS_GRP_DUTY) begin
        r_next.rdata = r_reg.grp_duty;
      end else if (reg_addr == `LDB_OFS_GRP_FREQ) begin
        r_next.rdata = r_reg.grp_freq;
      end else if (reg_addr == `LDB_OFS_CTRL2) begin
        r_next.rdata = r_reg.ctrl2;
      end else if (reg_addr < `LDB_OFS_OWN_ADDR) begin
        r_next.rdata = r_reg.mode[8*mi +: 8];
      end else if (reg_addr == `LDB_OFS_OWN_ADDR) begin
        r_next.rdata = {1'b0, r_reg.own_addr};
      end else if (reg_addr == `LDB_OFS_TX) begin
        r_next.rdata = r_reg.tx_byte;
      end else if (reg_addr == `LDB_OFS_RX) begin
        r_next.rdata = r_reg.rx_byte;
      end else if (reg_addr == `LDB_OFS_STATUS) begin
        r_next.rdata = {r_reg.rx_cnt[4:0], r_reg.nack, r_reg.rnw,
                        r_reg.st != LDB_IDLE};
      end
    end

    // Channel PWM timebase: 256 steps per 97 kHz period
    if (pwm_step) begin
      r_next.pwm_pre = 8'h00;
      r_next.pwm_cnt = r_reg.pwm_cnt + 8'h01;
    end else begin
      r_next.pwm_pre = r_reg.pwm_pre + 8'h01;
    end

    // Group timebase, one generator shared by dim and blink
    if (grp_step) begin
      r_next.grp_pre = 32'h0;
      r_next.grp_cnt = r_reg.grp_cnt + 8'h01;
    end else begin
      r_next.grp_pre = r_reg.grp_pre + 32'h1;
    end

    // Output stage per channel
    for (int i = 0; i < 16; i++) begin
      ind = (r_reg.pwm_cnt < r_reg.duty[i]);
      case (ldb_mode_of(r_reg.mode, i))
        2'b00: begin
          r_next.led[i] = 1'b0;
        end
        2'b01: begin
          r_next.led[i] = 1'b1;
        end
        2'b10: begin
          r_next.led[i] = ind;
        end
        default: begin
          r_next.led[i] = ind && grp_on;
        end
      endcase
    end

    // ======================================================
    // Serial slave: start and stop override bit activity
    r_next.sda_o = 1'b0;
    if (i2c_start) begin
      r_next.st = LDB_ADDR;
      r_next.bitc = 3'h0;
      r_next.full = 1'b0;
      r_next.sda_oe = 1'b0;
      r_next.nack = 1'b0;
    end else if (i2c_stop) begin
      r_next.st = LDB_IDLE;
      r_next.sda_oe = 1'b0;
    end else if (scl_rise) begin
      // Sample while SCL is high
      case (r_reg.st)
        LDB_ADDR, LDB_RX: begin
          r_next.sh = {r_reg.sh[6:0], r_reg.sda_s2};
          r_next.bitc = r_reg.bitc + 3'h1;
          r_next.full = (r_reg.bitc == 3'h7);
        end
        LDB_TX: begin
          r_next.bitc = r_reg.bitc + 3'h1;
        end
        LDB_ACK_TX: begin
          r_next.acked = !r_reg.sda_s2;
          if (r_reg.sda_s2) begin
            r_next.nack = 1'b1;
            r_next.sda_oe = 1'b0;
            r_next.st = LDB_IDLE;
          end
        end
        default: begin
        end
      endcase
    end else if (scl_fall) begin
      // Drive changes only while SCL is low
      case (r_reg.st)
        LDB_ADDR: begin
          if (r_reg.full) begin
            r_next.full = 1'b0;
            if (r_reg.sh[7:1] == r_reg.own_addr) begin
              r_next.sda_oe = 1'b1;
              r_next.rnw = r_reg.sh[0];
              r_next.st = LDB_ACK_A;
            end else begin
              r_next.st = LDB_IDLE;
            end
          end
        end
        LDB_RX: begin
          if (r_reg.full) begin
            r_next.full = 1'b0;
            r_next.rx_byte = r_reg.sh;
            r_next.rx_cnt = r_reg.rx_cnt + 8'h01;
            r_next.sda_oe = 1'b1;
            r_next.st = LDB_ACK_RX;
          end
        end
        LDB_ACK_RX: begin
          r_next.sda_oe = 1'b0;
          r_next.st = LDB_RX;
        end
        LDB_ACK_A: begin
          r_next.bitc = 3'h0;
          if (r_reg.rnw) begin
            r_next.sh = r_reg.tx_byte;
            r_next.sda_oe = !r_reg.tx_byte[7];
            r_next.st = LDB_TX;
          end else begin
            r_next.sda_oe = 1'b0;
            r_next.st = LDB_RX;
          end
        end
        LDB_TX: begin
          if (r_reg.bitc == 3'h0) begin
            r_next.sda_oe = 1'b0;
            r_next.st = LDB_ACK_TX;
          end else begin
            r_next.sh = {r_reg.sh[6:0], 1'b0};
            r_next.sda_oe = !r_reg.sh[6];
          end
        end
        LDB_ACK_TX: begin
          r_next.bitc = 3'h0;
          r_next.sh = r_reg.tx_byte;
          r_next.sda_oe = !r_reg.tx_byte[7];
          r_next.st = LDB_TX;
        end
        default: begin
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      r_reg <= LDB_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  // Outputs straight from the state register
  assign reg_rdata = r_reg.rdata;
  assign sda_out = r_reg.sda_o;
  assign sda_oe = r_reg.sda_oe;
  assign led_on = r_reg.led;

  // ========================================================
  // Checks
  default clocking ldb_cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);

  AST_PWM_PERIOD: assert property (
    pwm_step |=> !pwm_step [*3] ##1 pwm_step)
    else $error("channel step spacing wrong");

  AST_DUTY_ZERO: assert property (
    (ldb_mode_of(r_reg.mode, 0) == 2'b10 && r_reg.duty[0] == 8'h00)
    |=> !led_on[0])
    else $error("zero duty drove output");

  AST_MODE_OFF: assert property (
    ldb_mode_of(r_reg.mode, 3) == 2'b00 |=> !led_on[3])
    else $error("off channel active");

  AST_MODE_ON: assert property (
    ldb_mode_of(r_reg.mode, 5) == 2'b01 |=> led_on[5])
    else $error("on channel inactive");

  AST_GROUP_GATE: assert property (
    (ldb_mode_of(r_reg.mode, 0) == 2'b11 && !grp_on) |=> !led_on[0])
    else $error("group gate ignored");

  AST_DIM_RATE: assert property (
    (!r_reg.ctrl2[`LDB_BLINK_BIT] && $stable(r_reg.ctrl2))
    |-> r_reg.grp_pre < 32'(DIM_DIV))
    else $error("dimming period wrong");

  AST_BLINK_RATE: assert property (
    (r_reg.ctrl2[`LDB_BLINK_BIT] && $stable(r_reg.ctrl2)
     && $stable(r_reg.grp_freq)) |-> r_reg.grp_pre < grp_lim)
    else $error("blink period wrong");

  AST_START: assert property (
    i2c_start |=> r_reg.st == LDB_ADDR && r_reg.bitc == 3'h0
                  && !sda_oe)
    else $error("start not taken");

  AST_STOP: assert property (
    i2c_stop |=> r_reg.st == LDB_IDLE && !sda_oe)
    else $error("stop not taken");

  AST_ACK_HOLD: assert property (
    (r_reg.st == LDB_ACK_RX && r_reg.scl_s2) |-> sda_oe && !sda_out)
    else $error("ack not held low");

  AST_SDA_STABLE: assert property (
    (scl_hi && $past(scl_hi) && !i2c_stop && !i2c_start)
    |-> $stable(sda_oe))
    else $error("SDA moved while SCL high");

  AST_NACK_RELEASE: assert property (
    (r_reg.st == LDB_ACK_TX && scl_rise && r_reg.sda_s2 && !i2c_stop)
    |=> (r_reg.st == LDB_IDLE && !sda_oe) [*2])
    else $error("SDA not released after nack");

endmodule : ldb_top

// file: verif/ldb_i2c_mst.sv
// Bus master model that drives the serial slave port
`timescale 1ns/1ps
module ldb_i2c_mst (
  input wire logic ref_clk,
  input wire logic sda_bus,
  output logic scl,
  output logic sda_m,
  output logic viol
);
  // ==========================================================
  // Both lines released high while idle
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
    viol = 1'b0;
  end
  // Data changes only while SCL is low
  task automatic bit_out(input logic b);
    repeat (4) @(posedge ref_clk);
    sda_m <= b;
    repeat (4) @(posedge ref_clk);
    scl <= 1'b1;
    repeat (8) @(posedge ref_clk);
    scl <= 1'b0;
  endtask : bit_out
  // SDA released, sampled at both ends of the high phase
  task automatic bit_in(output logic b);
    logic first;
    repeat (4) @(posedge ref_clk);
    sda_m <= 1'b1;
    repeat (4) @(posedge ref_clk);
    scl <= 1'b1;
    @(posedge ref_clk);
    first = sda_bus;
    repeat (7) @(posedge ref_clk);
    b = sda_bus;
    if (b !== first) viol <= 1'b1;
    scl <= 1'b0;
  endtask : bit_in
  // Start from idle or as a repeated start
  task automatic send_start;
    repeat (4) @(posedge ref_clk);
    sda_m <= 1'b1;
    repeat (4) @(posedge ref_clk);
    scl <= 1'b1;
    repeat (8) @(posedge ref_clk);
    sda_m <= 1'b0;
    repeat (8) @(posedge ref_clk);
    scl <= 1'b0;
  endtask : send_start
  // SDA rises while SCL is high, then the bus stays idle
  task automatic send_stop;
    repeat (4) @(posedge ref_clk);
    sda_m <= 1'b0;
    repeat (4) @(posedge ref_clk);
    scl <= 1'b1;
    repeat (8) @(posedge ref_clk);
    sda_m <= 1'b1;
    repeat (8) @(posedge ref_clk);
  endtask : send_stop
  // Eight bits MSB first, ninth clock with SDA released
  task automatic put_byte(input logic [7:0] d, output logic ack_n);
    for (int i = 7; i >= 0; i--) bit_out(d[i]);
    bit_in(ack_n);
  endtask : put_byte
  // Acknowledge every byte but the last
  task automatic get_byte(input logic last, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) bit_in(d[i]);
    bit_out(last);
  endtask : get_byte
endmodule : ldb_i2c_mst

// file: verif/test_led_dimming_blink_i2c_slave.sv
// Self-checking bench for the LED engine and its serial port
`timescale 1ns/1ps
`include "ldb_cfg.svh"
module test_led_dimming_blink_i2c_slave;
  // ==========================================================
  // Signals
  localparam int PER = `LDB_PWM_DIV * `LDB_PWM_STEPS;
  logic ref_clk, nrst, reg_wr, reg_rd, sda_out, sda_oe;
  logic scl, sda_m, viol;
  logic [4:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  logic [15:0] led_on;
  wire sda_bus;
  int n_mismatch, checks;
  logic [31:0] seed;
  // Open-drain SDA: wire-AND with the pull-up
  assign sda_bus = sda_m & (sda_oe ? sda_out : 1'b1);
  // ==========================================================
  // Design and bus master
  ldb_top #(
    .DIM_DIV(4),
    .BLINK_FAST_DIV(4),
    .BLINK_STEP_DIV(1)
  ) i_dut (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .scl_in(scl),
    .sda_in(sda_bus),
    .sda_out(sda_out),
    .sda_oe(sda_oe),
    .led_on(led_on)
  );
  ldb_i2c_mst i_mst (
    .ref_clk(ref_clk),
    .sda_bus(sda_bus),
    .scl(scl),
    .sda_m(sda_m),
    .viol(viol)
  );
  // ==========================================================
  // Clock, helpers and checks
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // Xorshift generator
  function automatic logic [7:0] rnd8();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction : rnd8
  // On cycles of a channel over one period
  function automatic int exp_on(input logic [7:0] d);
    return int'(d) * `LDB_PWM_DIV;
  endfunction : exp_on
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got %0h expected %0h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(posedge ref_clk);
    d = reg_rdata;
  endtask : rd
  task automatic rchk(input logic [4:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    chk(d, e);
  endtask : rchk
  // Counts on cycles and rising edges of one output
  task automatic meas(input int ch, input int n, output int on,
                      output int rs);
    logic prev;
    on = 0;
    rs = 0;
    prev = led_on[ch];
    repeat (n) begin
      @(posedge ref_clk);
      if (led_on[ch] === 1'b1) on++;
      if (led_on[ch] === 1'b1 && prev !== 1'b1) rs++;
      prev = led_on[ch];
    end
  endtask : meas
  task automatic wrap_up;
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up
  // Watchdog against a hung transfer
  initial begin
    repeat (60000) @(posedge ref_clk);
    n_mismatch++;
    $display("ERROR t=%0t watchdog expired", $time);
    wrap_up();
  end
  // ==========================================================
  // Main sequence
  initial begin
    logic [7:0] d, tx, last;
    logic [7:0] duty [4];
    logic ack_n;
    int on, rs;
    n_mismatch = 0;
    checks = 0;
    seed = 32'h000049B7;
    nrst = 1'b0;
    reg_addr = 5'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (16) @(posedge ref_clk);
    nrst <= 1'b1;
    // Reset values and an unmapped place
    rchk(`LDB_OFS_DUTY0, 8'h00);
    rchk(`LDB_OFS_OWN_ADDR, {1'b0, `LDB_OWN_ADDR_RST});
    wr(5'h1F, 8'hA5);
    rchk(5'h1F, 8'h00);
    // Random duties read back on every channel
    for (int ch = 0; ch < 16; ch++) begin
      d = rnd8();
      wr(5'(ch), d);
      rchk(5'(ch), d);
    end
    // Channel PWM alone: duty 00, two random, FF
    duty[0] = 8'h00;
    duty[1] = rnd8();
    duty[2] = rnd8();
    duty[3] = 8'hFF;
    for (int ch = 0; ch < 4; ch++) wr(5'(ch), duty[ch]);
    wr(`LDB_OFS_MODE0, 8'hAA);
    repeat (4) @(posedge ref_clk);
    for (int ch = 0; ch < 4; ch++) begin
      meas(ch, PER, on, rs);
      chk(on, exp_on(duty[ch]));
    end
    // Modes 11 with group duty 00, 01 and 00; channel 5 fully on
    wr(`LDB_OFS_DUTY0, 8'hFF);
    wr(5'h02, 8'h00);
    wr(`LDB_OFS_MODE0, 8'h1B);
    wr(5'h14, 8'h04);
    rchk(5'h14, 8'h04);
    repeat (4) @(posedge ref_clk);
    meas(0, PER, on, rs);
    chk(on, 0);
    meas(2, PER, on, rs);
    chk(on, PER);
    meas(3, PER, on, rs);
    chk(on, 0);
    meas(5, PER, on, rs);
    chk(on, PER);
    // Group at half duty: dimming, then slow blinking
    wr(`LDB_OFS_GRP_DUTY, 8'h80);
    repeat (64) @(posedge ref_clk);
    meas(0, 8192, on, rs);
    chk(on >= 4000 && on <= 4100, 1'b1);
    chk(rs >= 7, 1'b1);
    wr(`LDB_OFS_GRP_FREQ, 8'h1C);
    wr(`LDB_OFS_CTRL2, 8'h01);
    repeat (64) @(posedge ref_clk);
    meas(0, 8192, on, rs);
    chk(on >= 4000 && on <= 4100, 1'b1);
    chk(rs <= 6, 1'b1);
    // Serial write: own address and three data bytes
    i_mst.send_start();
    i_mst.put_byte({`LDB_OWN_ADDR_RST, 1'b0}, ack_n);
    chk(ack_n, 1'b0);
    rd(`LDB_OFS_STATUS, d);
    chk(d[0], 1'b1);
    for (int k = 0; k < 3; k++) begin
      last = rnd8();
      i_mst.put_byte(last, ack_n);
      chk(ack_n, 1'b0);
    end
    rchk(`LDB_OFS_RX, last);
    // Repeated start, read two bytes, refuse the second
    tx = rnd8();
    wr(`LDB_OFS_TX, tx);
    i_mst.send_start();
    i_mst.put_byte({`LDB_OWN_ADDR_RST, 1'b1}, ack_n);
    chk(ack_n, 1'b0);
    i_mst.get_byte(1'b0, d);
    chk(d, tx);
    i_mst.get_byte(1'b1, d);
    chk(d, tx);
    repeat (8) @(posedge ref_clk);
    chk(sda_oe, 1'b0);
    // After the refusal the slave is idle before any stop
    rd(`LDB_OFS_STATUS, d);
    chk(d & 8'h07, 8'h06);
    i_mst.send_stop();
    rd(`LDB_OFS_STATUS, d);
    chk(d & 8'h05, 8'h04);
    // Foreign address gets no acknowledge
    i_mst.send_start();
    i_mst.put_byte({~`LDB_OWN_ADDR_RST, 1'b0}, ack_n);
    chk(ack_n, 1'b1);
    i_mst.send_stop();
    chk(viol, 1'b0);
    wrap_up();
  end
endmodule : test_led_dimming_blink_i2c_slave
